// ==== hw/asram_ctrl.sv ====
// Controller that drives an asynchronous 128K x 8 static memory.
`timescale 1ns/1ns
`default_nettype none
`include "asram_map.svh"

module asram_ctrl (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // User request port.
  input  wire logic                      req_valid,
  input  wire asram_pkg::asram_req_t     req,
  output var  logic                      req_ready,
  output var  logic                      rsp_valid,
  output var  logic [`ASRAM_DATA_W-1:0]  rsp_rdata,
  // Power warning: while high no new access starts; one under way runs to its end.
  input  wire logic                      power_fail,
  // Memory pins.
  output var  logic [`ASRAM_ADDR_W-1:0]  address_lines,
  output var  asram_pkg::asram_strobe_t  strobe,
  input  wire logic [`ASRAM_DATA_W-1:0]  data_lines_in,
  output var  logic [`ASRAM_DATA_W-1:0]  data_lines_out,
  output var  logic                      data_lines_oe
);

  // Controller states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_RD_END, ST_WR_SETUP, ST_WR, ST_WR_END
  } asram_state_t;

  asram_state_t             state_r;    // Current state.
  logic [`ASRAM_CNT_W-1:0]  cnt_r;      // Phase timer.
  logic [`ASRAM_DATA_W-1:0] rd_sync;    // Synchronised data lines.

  // Data lines come from the memory's clockless domain.
  asram_sync u_sync (
    .clk     (clk),
    .arst_n  (arst_n),
    .pin_in  (data_lines_in),
    .settled (rd_sync)
  );

  // Wait for access time, the three-flop synchroniser and the stage that
  // only takes a value once stages two and three agree.
  localparam logic [3:0] RD_WAIT = 4'(`ASRAM_ACCESS_CYC + `ASRAM_RD_SYNC_CYC);
  localparam logic [3:0] WR_WAIT = 4'(`ASRAM_WPULSE_CYC);

  // Sequencer: one access at a time, strobes and pins from flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r        <= ST_IDLE;
      cnt_r          <= 4'h0;
      req_ready      <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_rdata      <= 8'h00;
      address_lines  <= 17'h0_0000;
      strobe         <= 3'b111;
      data_lines_out <= 8'h00;
      data_lines_oe  <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Idle keeps the memory deselected so it stands by.
          strobe        <= 3'b111;
          data_lines_oe <= 1'b0;
          req_ready     <= !power_fail;
          if (req_valid && req_ready && !power_fail) begin
            req_ready     <= 1'b0;
            address_lines <= req.addr;
            cnt_r         <= 4'h0;
            if (req.write) begin
              // Address settles with everything still high.
              data_lines_out <= req.wdata;
              state_r        <= ST_WR_SETUP;
            end else begin
              // Select and enable output, write strobe high.
              strobe  <= 3'b001;
              state_r <= ST_RD;
            end
          end
        end
        ST_RD: begin
          // Hold the address through the access time.
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == RD_WAIT - 4'h1) begin
            rsp_rdata <= rd_sync;
            rsp_valid <= 1'b1;
            strobe    <= 3'b111;
            cnt_r     <= 4'h0;
            state_r   <= ST_RD_END;
          end
        end
        ST_RD_END: begin
          // Let the memory release the bus before any drive.
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(`ASRAM_CYCLE_CYC - 1)) begin
            state_r <= ST_IDLE;
          end
        end
        ST_WR_SETUP: begin
          // Select and lower the write strobe, output disabled, driving data in the same cycle.
          strobe        <= 3'b010;
          data_lines_oe <= 1'b1;
          state_r       <= ST_WR;
        end
        ST_WR: begin
          // Write pulse covers turn-off plus data setup.
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == WR_WAIT - 4'h1) begin
            // Write strobe alone ends the write.
            strobe  <= 3'b011;
            state_r <= ST_WR_END;
          end
        end
        ST_WR_END: begin
          // Data and address held one cycle past the end.
          strobe        <= 3'b111;
          data_lines_oe <= 1'b0;
          state_r       <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Write data must be driven whenever the write strobe is low.
  a_wr_data_drv: assert property (
    @(posedge clk) disable iff (!arst_n)
    !strobe.we_n |-> data_lines_oe)
    else $error("write without data");
  // Output enable and drive never overlap.
  a_no_contend: assert property (
    @(posedge clk) disable iff (!arst_n)
    !strobe.oe_n |-> !data_lines_oe)
    else $error("bus contention");
  // Write pulse is at least the required length.
  a_wr_pulse: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(strobe.we_n) |-> !strobe.we_n [*4])
    else $error("short write");
  // Address is stable while the write strobe is low and one cycle past.
  a_wr_addr: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!strobe.we_n || !$past(strobe.we_n)) |-> $stable(address_lines))
    else $error("address moved in write");
  // Write ends by the strobe while select stays low.
  a_wr_end: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(strobe.we_n) |-> !strobe.ce_n)
    else $error("bad write end");
  // Read response comes a fixed time after select: access time, the
  // synchroniser with its agreeing stage, then the registered pulse.
  a_rd_time: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($fell(strobe.ce_n) && !strobe.oe_n) |-> ##8 rsp_valid)
    else $error("read timing");
  // Write never happens with output enabled.
  a_wr_oe_hi: assert property (
    @(posedge clk) disable iff (!arst_n)
    !strobe.we_n |-> strobe.oe_n)
    else $error("oe low in write");
  // Power warning in idle keeps the memory deselected.
  a_pwr_desel: assert property (
    @(posedge clk) disable iff (!arst_n)
    (power_fail && state_r == ST_IDLE) |=> strobe.ce_n)
    else $error("selected in power fail");
  // A read never has the write strobe low with it.
  a_rd_we_hi: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!strobe.ce_n && !strobe.oe_n) |-> strobe.we_n)
    else $error("write strobe low in read");
  // The write strobe only goes low with the memory selected.
  a_wr_ce_low: assert property (
    @(posedge clk) disable iff (!arst_n)
    !strobe.we_n |-> !strobe.ce_n)
    else $error("write while deselected");
  // Write data does not move while the write strobe is low.
  a_wr_data_stable: assert property (
    @(posedge clk) disable iff (!arst_n)
    !strobe.we_n |-> $stable(data_lines_out))
    else $error("write data moved");
  // Data is still driven and unchanged at the edge that ends the write.
  a_wr_data_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(strobe.we_n) |-> (data_lines_oe && $stable(data_lines_out)))
    else $error("write data not held");
  // The address has already settled when the write strobe falls.
  a_wr_addr_setup: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(strobe.we_n) |-> $stable(address_lines))
    else $error("address late for write");
  // The strobe that ends a write was already low four samples earlier.
  a_wr_len: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(strobe.we_n) |-> !$past(strobe.we_n, 4))
    else $error("write pulse too short");
  // Idle always leaves the memory deselected, so it stands by.
  a_idle_desel: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_r == ST_IDLE) |-> strobe.ce_n)
    else $error("selected while idle");
  // The controller never drives while a read is in progress.
  a_rd_no_drive: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_r == ST_RD) |-> !data_lines_oe)
    else $error("drive during read");
  // Deselecting the memory never coincides with driving the lines.
  a_desel_float: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(strobe.ce_n) |-> !data_lines_oe)
    else $error("drive at deselect");
  // After a read, the memory gets time to release the lines.
  a_rd_turnaround: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(strobe.oe_n) |-> !data_lines_oe [*4])
    else $error("drive too soon after read");
  // Ready is only offered when the power warning was low.
  a_ready_power: assert property (
    @(posedge clk) disable iff (!arst_n)
    req_ready |-> !$past(power_fail))
    else $error("ready during power warning");
  // The address stays put for the whole read access.
  a_rd_addr_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_r == ST_RD && $past(state_r) == ST_RD) |-> $stable(address_lines))
    else $error("address moved in read");
  // The read response is a single-cycle pulse.
  a_rsp_pulse: assert property (
    @(posedge clk) disable iff (!arst_n)
    rsp_valid |=> !rsp_valid)
    else $error("response pulse too long");

endmodule : asram_ctrl
`default_nettype wire

// ==== hw/asram_map.svh ====
// Timing counts and widths for the async SRAM controller.
`ifndef ASRAM_MAP_SVH
`define ASRAM_MAP_SVH

`define ASRAM_CLK_PERIOD_NS        4
`define ASRAM_ADDR_W               17
`define ASRAM_DATA_W               8
`define ASRAM_DEPTH                131072
// Slowest speed grade figures, in ns.
`define ASRAM_ACCESS_NS            15
`define ASRAM_CYCLE_NS             15
`define ASRAM_ADDR_SETUP_NS        10
`define ASRAM_DATA_SETUP_NS        8
`define ASRAM_TURNOFF_NS           7
`define ASRAM_STANDBY_NS           15
`define ASRAM_DESEL_RET_NS         0
// Cycle counts, least times rounded up.
`define ASRAM_ACCESS_CYC  ((`ASRAM_ACCESS_NS + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_CYCLE_CYC   ((`ASRAM_CYCLE_NS + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_WPULSE_NS   (`ASRAM_TURNOFF_NS + `ASRAM_DATA_SETUP_NS)
`define ASRAM_WPULSE_CYC  ((`ASRAM_WPULSE_NS + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_CNT_W       4
// Read path flops after the access time: three synchroniser stages and
// the stage that waits for the last two of them to agree.
`define ASRAM_RD_SYNC_CYC 4

`endif

// ==== hw/asram_pkg.sv ====
// Types shared by the async SRAM controller files.
package asram_pkg;

  // One request from the user side.
  typedef struct packed {
    logic        write;
    logic [16:0] addr;
    logic [7:0]  wdata;
  } asram_req_t;

  // Strobes toward the memory, all active low.
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } asram_strobe_t;

endpackage : asram_pkg

// ==== hw/asram_sync.sv ====
// Three-stage input synchroniser for the returned data lines.
`timescale 1ns/1ns
`default_nettype none
`include "asram_map.svh"

module asram_sync (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // Raw pin and settled value.
  input  wire logic [`ASRAM_DATA_W-1:0]  pin_in,
  output var  logic [`ASRAM_DATA_W-1:0]  settled
);

  logic [`ASRAM_DATA_W-1:0] s1_r;  // First stage, read only by s2_r.
  logic [`ASRAM_DATA_W-1:0] s2_r;  // Second stage.
  logic [`ASRAM_DATA_W-1:0] s3_r;  // Third stage.

  // Shift the pin value through three flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Update the settled value only once stages two and three agree.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settled <= 8'h00;
    end else if (s2_r == s3_r) begin
      settled <= s3_r;
    end
  end

endmodule : asram_sync
`default_nettype wire

// ==== bench/asram_mem_model.sv ====
// Behavioural model of the 128K x 8 asynchronous static memory.
`timescale 1ns/1ns
`default_nettype none
`include "asram_map.svh"

module asram_mem_model (
  // Memory pins as seen by the device.
  input  wire logic [16:0]              address_lines,
  input  wire asram_pkg::asram_strobe_t strobe,
  input  wire logic [7:0]               data_lines,
  // Read data and drive enable toward the wire.
  output var  logic [7:0]               mdata,
  output var  logic                     mdrv
);
  // Storage array, one byte per location.
  logic [7:0] mem [0:131071];
  logic       wr_act;         // Select and write strobe overlap.
  logic [7:0] acc;            // Byte at the current address.
  event       stored;         // A write has just been stored.

  // A write lasts while select and write strobe are both low.
  assign wr_act = !strobe.ce_n && !strobe.we_n;

  // Store on the edge that ends the write, whichever strobe rises. Only
  // a write that has begun counts, so the strobes settling out of reset
  // store nothing. Contents change nowhere else.
  always @(posedge wr_act) begin
    @(negedge wr_act);
    mem[address_lines] = data_lines;
    -> stored;
  end

  // Read byte follows the address, or a fresh write, after the slowest
  // access time, so the old byte stays on the lines for a while.
  always @(address_lines or stored) begin
    acc <= #(`ASRAM_ACCESS_NS) mem[address_lines];
  end
  assign mdata = acc;

  // Drive only when selected, outputs enabled and not writing; a
  // deselected or simultaneous-rise part stays off the lines.
  assign mdrv = !strobe.ce_n && !strobe.oe_n && strobe.we_n;
endmodule : asram_mem_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking testbench for the async SRAM controller.
`timescale 1ns/1ns
`default_nettype none
`include "asram_map.svh"

module tb;
  logic                     clk = 0, arst_n = 0, req_valid = 0;
  logic                     power_fail = 0, req_ready, rsp_valid;
  asram_pkg::asram_req_t    req = '0;
  asram_pkg::asram_strobe_t strobe;
  logic [7:0]               rsp_rdata, dout, mdata, dq, dq_last = 0;
  logic [16:0]              address_lines;
  logic                     doe, mdrv;
  int                       failures = 0, n_checks = 0;

  always #2 clk = ~clk;
  // Wire level: whoever drives, else a pattern that changes each cycle.
  assign dq = doe ? dout : (mdrv ? mdata : ~dq_last);
  always @(posedge clk) dq_last <= dq;

  asram_ctrl i_asram_ctrl (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .power_fail(power_fail), .address_lines(address_lines),
    .strobe(strobe), .data_lines_in(dq), .data_lines_out(dout),
    .data_lines_oe(doe));
  asram_mem_model i_asram_mem_model (.address_lines(address_lines),
    .strobe(strobe), .data_lines(dq), .mdata(mdata), .mdrv(mdrv));

  // Compare a seen value against the expected one.
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Both parties on the lines at once is contention.
  always @(posedge clk) if (doe && mdrv) check(1'b1, 1'b0);

  // Issue one request; for reads compare the byte and its latency.
  task automatic access(input logic w, input logic [16:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req       <= '{write: w, addr: a, wdata: d};
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check(req_ready, 1'b1);
    req_valid <= 1'b0;
    n = 0;
    while (w == 1'b0 && rsp_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    // Access time, four read-path stages, then the pulse seen an edge on.
    if (!w) check(n, `ASRAM_ACCESS_CYC + `ASRAM_RD_SYNC_CYC + 1);
    if (!w) check(rsp_rdata, d);
    repeat (2) @(posedge clk);
  endtask : access

  // Boundary addresses, written back to back, then read back.
  task automatic t_bounds;
    access(1'b1, 17'h0_0000, 8'hA5);
    access(1'b1, 17'h1_FFFF, 8'h5A);
    access(1'b1, 17'h0_0001, 8'h3C);
    access(1'b0, 17'h0_0000, 8'hA5);
    access(1'b0, 17'h1_FFFF, 8'h5A);
    access(1'b0, 17'h0_0001, 8'h3C);
    $display("test bounds done");
  endtask : t_bounds

  // Power warning blocks access and keeps the memory deselected.
  task automatic t_power;
    power_fail <= 1'b1;
    req_valid  <= 1'b1;
    req        <= '{write: 1'b1, addr: 17'h0_0000, wdata: 8'hFF};
    repeat (12) @(posedge clk);
    check(req_ready, 1'b0);
    check(strobe.ce_n, 1'b1);
    req_valid  <= 1'b0;
    power_fail <= 1'b0;
    repeat (3) @(posedge clk);
    access(1'b0, 17'h0_0000, 8'hA5);
    $display("test power done");
  endtask : t_power

  // Print counts and the verdict, then end the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(req_ready, 1'b1);
    check(strobe, 3'b111);
    t_bounds;
    t_power;
    stop_test;
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #20000;
    failures++;
    stop_test;
  end
endmodule : tb
`default_nettype wire
